// >>> inc/pmic_regs_pkg.sv
// package: register map, field layout and reset values of the regulator control bank
package pmic_regs_pkg;

	localparam int          ADDR_W = 8;
	localparam int          DATA_W = 8;

	// register byte addresses
	localparam logic [7:0]  OFS_LDO_ONE_VOLTAGE   = 8'h02;
	localparam logic [7:0]  OFS_LDO_TWO_VOLTAGE   = 8'h03;
	localparam logic [7:0]  OFS_BUCK_PARAMETERS   = 8'h04;
	localparam logic [7:0]  OFS_SYSTEM_PARAMETERS = 8'h05;
	localparam logic [7:0]  OFS_BUCK_SLEW_CONTROL = 8'h06;

	// writable bit masks; all other bits are reserved
	localparam logic [7:0]  MASK_LDO_VOLTAGE      = 8'h3F;
	localparam logic [7:0]  MASK_BUCK_PARAMETERS  = 8'h7F;
	localparam logic [7:0]  MASK_SYSTEM_PARAMS    = 8'h7F;
	localparam logic [7:0]  MASK_BUCK_SLEW        = 8'hEE;

	// reset values
	localparam logic [7:0]  RST_LDO_VOLTAGE       = 8'h0C;
	localparam logic [7:0]  RST_BUCK_PARAMETERS   = 8'h0F;
	localparam logic [7:0]  RST_SYSTEM_PARAMS     = 8'h2F;
	localparam logic [7:0]  RST_BUCK_SLEW         = 8'h22;

	// field positions
	localparam int          POS_PHASE_SEL         = 6;
	localparam int          POS_TWO_ULTRA         = 5;
	localparam int          POS_ONE_ULTRA         = 4;
	localparam int          POS_TWO_DISCHARGE     = 3;
	localparam int          POS_ONE_DISCHARGE     = 2;
	localparam int          POS_TWO_AUTO          = 1;
	localparam int          POS_ONE_AUTO          = 0;
	localparam int          POS_IF_EN             = 6;
	localparam int          POS_POR_DELAY_LO      = 4;
	localparam int          POS_LDO_TWO_EN        = 3;
	localparam int          POS_LDO_ONE_EN        = 2;
	localparam int          POS_BUCK_TWO_EN       = 1;
	localparam int          POS_BUCK_ONE_EN       = 0;
	localparam int          POS_TWO_SLEW_LO       = 5;
	localparam int          POS_ONE_SLEW_LO       = 1;

	// power-on delay codes
	localparam logic [1:0]  POR_DELAY_1MS         = 2'h0;
	localparam logic [1:0]  POR_DELAY_50MS        = 2'h1;
	localparam logic [1:0]  POR_DELAY_150MS       = 2'h2;
	localparam logic [1:0]  POR_DELAY_200MS       = 2'h3;

	// register access request from the serial interface
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_t;

	// control levels toward the analog regulators
	typedef struct packed {
		logic [5:0] ldo_one_code;
		logic [5:0] ldo_two_code;
		logic       buck_phase_select;
		logic       buck_two_ultrasonic_en;
		logic       buck_one_ultrasonic_en;
		logic       buck_two_discharge_en;
		logic       buck_one_discharge_en;
		logic       buck_two_auto_mode;
		logic       buck_one_auto_mode;
		logic       if_func_en;
		logic [1:0] power_on_delay_sel;
		logic       ldo_two_en;
		logic       ldo_one_en;
		logic       buck_two_en;
		logic       buck_one_en;
		logic [2:0] buck_two_slew_sel;
		logic [2:0] buck_one_slew_sel;
	} reg_ctrl_t;

endpackage : pmic_regs_pkg

// >>> rtl/ctrl_reg8.sv
// one 8-bit control register with writable mask and reset value
`timescale 1ns/1ps
`default_nettype none
module ctrl_reg8 #(
	parameter logic [7:0] RST_VAL = 8'h00,
	parameter logic [7:0] WR_MASK = 8'hFF
) (
	// clock and reset
	input  wire logic       i_mclk,
	input  wire logic       i_rst_n,
	// write port
	input  wire logic       i_we,
	input  wire logic [7:0] i_wdata,
	// stored value
	output logic      [7:0] o_q
);
	logic [7:0] q_r;
	logic [7:0] q_nxt;

	always_comb begin
		q_nxt = q_r;
		// reserved bits hold reset value
		if (i_we) begin
			q_nxt = (i_wdata & WR_MASK) | (RST_VAL & ~WR_MASK);
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q_r <= RST_VAL;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign o_q = q_r;
endmodule : ctrl_reg8
`default_nettype wire

// >>> rtl/pmic_regulator_control_regs.sv
// regulator control register bank reached by the serial host interface
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RL1: two six-bit ldo voltage codes, bits 7:6 reserved
// RL2: ldo code steps 50 mV from 0.90 V
// RL3: ldo voltage registers reset to code 0x0C
// RL4: bit 6 selects in-phase or 180 degrees
// RL5: ultrasonic enables per buck, reset off
// RL6: active discharge enables per buck, reset on
// RL7: auto pfm/pwm mode bits, reset to auto
// RL8: interface function enable bit, reset off
// RL9: power-on delay select, reset to 150 ms
// RL10: four regulator enables, all reset on
// RL11: buck two slew code bits 7:5, reset 001
// RL12: buck one slew code bits 3:1, reset 001
// RL13: all registers load defaults at start-up
// RL14: reserved bits read zero, writes ignored
module pmic_regulator_control_regs (
	// clock and reset
	input  wire logic                       i_mclk,
	input  wire logic                       i_rst_n,
	// register access from the serial slave
	input  wire pmic_regs_pkg::reg_req_t    i_req,
	output logic                            o_ack,
	output logic                            o_addr_hit,
	output logic [7:0]                      o_rdata,
	// controls to the analog regulators
	output var pmic_regs_pkg::reg_ctrl_t    o_ctrl,
	output logic [6:0]                      o_ldo_one_mv_step,
	output logic [6:0]                      o_ldo_two_mv_step
);
	logic [7:0]  ldo_one_q;
	logic [7:0]  ldo_two_q;
	logic [7:0]  buck_par_q;
	logic [7:0]  sys_par_q;
	logic [7:0]  slew_q;
	logic        we_ldo_one;
	logic        we_ldo_two;
	logic        we_buck_par;
	logic        we_sys_par;
	logic        we_slew;
	logic        hit;
	logic [7:0]  rdata_r;
	logic [7:0]  rdata_nxt;
	logic        ack_r;
	logic        ack_nxt;

	// address decode
	always_comb begin
		we_ldo_one  = i_req.wr && (i_req.addr == pmic_regs_pkg::OFS_LDO_ONE_VOLTAGE);
		we_ldo_two  = i_req.wr && (i_req.addr == pmic_regs_pkg::OFS_LDO_TWO_VOLTAGE);
		we_buck_par = i_req.wr && (i_req.addr == pmic_regs_pkg::OFS_BUCK_PARAMETERS);
		we_sys_par  = i_req.wr && (i_req.addr == pmic_regs_pkg::OFS_SYSTEM_PARAMETERS);
		we_slew     = i_req.wr && (i_req.addr == pmic_regs_pkg::OFS_BUCK_SLEW_CONTROL);
		hit = (i_req.addr >= pmic_regs_pkg::OFS_LDO_ONE_VOLTAGE)
		   && (i_req.addr <= pmic_regs_pkg::OFS_BUCK_SLEW_CONTROL);
	end

	// RL1 RL3 RL13 ldo voltage registers
	ctrl_reg8 #(
		.RST_VAL (pmic_regs_pkg::RST_LDO_VOLTAGE),
		.WR_MASK (pmic_regs_pkg::MASK_LDO_VOLTAGE)
	) u_ldo_one (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_we    (we_ldo_one),
		.i_wdata (i_req.wdata),
		.o_q     (ldo_one_q)
	);

	ctrl_reg8 #(
		.RST_VAL (pmic_regs_pkg::RST_LDO_VOLTAGE),
		.WR_MASK (pmic_regs_pkg::MASK_LDO_VOLTAGE)
	) u_ldo_two (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_we    (we_ldo_two),
		.i_wdata (i_req.wdata),
		.o_q     (ldo_two_q)
	);

	// RL4 RL5 RL6 RL7 buck parameter register
	ctrl_reg8 #(
		.RST_VAL (pmic_regs_pkg::RST_BUCK_PARAMETERS),
		.WR_MASK (pmic_regs_pkg::MASK_BUCK_PARAMETERS)
	) u_buck_par (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_we    (we_buck_par),
		.i_wdata (i_req.wdata),
		.o_q     (buck_par_q)
	);

	// RL8 RL9 RL10 system register
	ctrl_reg8 #(
		.RST_VAL (pmic_regs_pkg::RST_SYSTEM_PARAMS),
		.WR_MASK (pmic_regs_pkg::MASK_SYSTEM_PARAMS)
	) u_sys_par (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_we    (we_sys_par),
		.i_wdata (i_req.wdata),
		.o_q     (sys_par_q)
	);

	// RL11 RL12 slew register
	ctrl_reg8 #(
		.RST_VAL (pmic_regs_pkg::RST_BUCK_SLEW),
		.WR_MASK (pmic_regs_pkg::MASK_BUCK_SLEW)
	) u_slew (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_we    (we_slew),
		.i_wdata (i_req.wdata),
		.o_q     (slew_q)
	);

	// read mux; unmapped addresses read zero
	always_comb begin
		rdata_nxt = rdata_r;
		ack_nxt   = i_req.wr || i_req.rd;
		if (i_req.rd) begin
			// RL14 reserved read zero
			unique case (i_req.addr)
				pmic_regs_pkg::OFS_LDO_ONE_VOLTAGE:   rdata_nxt = ldo_one_q & pmic_regs_pkg::MASK_LDO_VOLTAGE;
				pmic_regs_pkg::OFS_LDO_TWO_VOLTAGE:   rdata_nxt = ldo_two_q & pmic_regs_pkg::MASK_LDO_VOLTAGE;
				pmic_regs_pkg::OFS_BUCK_PARAMETERS:   rdata_nxt = buck_par_q & pmic_regs_pkg::MASK_BUCK_PARAMETERS;
				pmic_regs_pkg::OFS_SYSTEM_PARAMETERS: rdata_nxt = sys_par_q & pmic_regs_pkg::MASK_SYSTEM_PARAMS;
				pmic_regs_pkg::OFS_BUCK_SLEW_CONTROL: rdata_nxt = slew_q & pmic_regs_pkg::MASK_BUCK_SLEW;
				default:                              rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_r <= 8'h00;
			ack_r   <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			ack_r   <= ack_nxt;
		end
	end

	assign o_rdata    = rdata_r;
	assign o_ack      = ack_r;
	assign o_addr_hit = hit;

	// field fan-out to the analog side
	always_comb begin
		o_ctrl.ldo_one_code           = ldo_one_q[5:0];
		o_ctrl.ldo_two_code           = ldo_two_q[5:0];
		// RL4 phase select
		o_ctrl.buck_phase_select      = buck_par_q[pmic_regs_pkg::POS_PHASE_SEL];
		// RL5 ultrasonic enables
		o_ctrl.buck_two_ultrasonic_en = buck_par_q[pmic_regs_pkg::POS_TWO_ULTRA];
		o_ctrl.buck_one_ultrasonic_en = buck_par_q[pmic_regs_pkg::POS_ONE_ULTRA];
		// RL6 discharge enables
		o_ctrl.buck_two_discharge_en  = buck_par_q[pmic_regs_pkg::POS_TWO_DISCHARGE];
		o_ctrl.buck_one_discharge_en  = buck_par_q[pmic_regs_pkg::POS_ONE_DISCHARGE];
		// RL7 mode bits
		o_ctrl.buck_two_auto_mode     = buck_par_q[pmic_regs_pkg::POS_TWO_AUTO];
		o_ctrl.buck_one_auto_mode     = buck_par_q[pmic_regs_pkg::POS_ONE_AUTO];
		// RL8 interface enable
		o_ctrl.if_func_en             = sys_par_q[pmic_regs_pkg::POS_IF_EN];
		// RL9 power-on delay
		o_ctrl.power_on_delay_sel     = sys_par_q[pmic_regs_pkg::POS_POR_DELAY_LO +: 2];
		// RL10 regulator enables
		o_ctrl.ldo_two_en             = sys_par_q[pmic_regs_pkg::POS_LDO_TWO_EN];
		o_ctrl.ldo_one_en             = sys_par_q[pmic_regs_pkg::POS_LDO_ONE_EN];
		o_ctrl.buck_two_en            = sys_par_q[pmic_regs_pkg::POS_BUCK_TWO_EN];
		o_ctrl.buck_one_en            = sys_par_q[pmic_regs_pkg::POS_BUCK_ONE_EN];
		// RL11 RL12 slew codes
		o_ctrl.buck_two_slew_sel      = slew_q[pmic_regs_pkg::POS_TWO_SLEW_LO +: 3];
		o_ctrl.buck_one_slew_sel      = slew_q[pmic_regs_pkg::POS_ONE_SLEW_LO +: 3];
	end

	// RL2 code is the count of 50 mV steps above 0.90 V; above 0x36 undefined, passed as is
	assign o_ldo_one_mv_step = {1'b0, ldo_one_q[5:0]};
	assign o_ldo_two_mv_step = {1'b0, ldo_two_q[5:0]};
endmodule : pmic_regulator_control_regs
`default_nettype wire

// >>> sim/pmic_regs_checker_assertions.sv
// checker: port-level relations of the regulator control bank
`timescale 1ns/1ps
`default_nettype none
module pmic_regs_checker (
	// clock and reset
	input wire logic                     i_mclk,
	input wire logic                     i_rst_n,
	// register access
	input wire pmic_regs_pkg::reg_req_t  i_req,
	input wire logic                     o_ack,
	input wire logic                     o_addr_hit,
	input wire logic [7:0]               o_rdata,
	// regulator controls
	input wire pmic_regs_pkg::reg_ctrl_t o_ctrl,
	input wire logic [6:0]               o_ldo_one_mv_step,
	input wire logic [6:0]               o_ldo_two_mv_step
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	sequence s_wr(logic [7:0] a);
		i_req.wr && i_req.addr == a;
	endsequence
	// a read only, so no write can move the fields meanwhile
	sequence s_rd(logic [7:0] a);
		i_req.rd && !i_req.wr && i_req.addr == a;
	endsequence
	a_ldo_one_write: assert property (s_wr(8'h02) |=> o_ctrl.ldo_one_code == $past(i_req.wdata[5:0]))
		else $error("ldo one code not written");
	a_ldo_two_write: assert property (s_wr(8'h03) |=> o_ctrl.ldo_two_code == $past(i_req.wdata[5:0]))
		else $error("ldo two code not written");
	a_ldo_step_map: assert property (o_ldo_two_mv_step == {1'b0, o_ctrl.ldo_two_code})
		else $error("ldo step count wrong");
	a_buck_par_write: assert property (s_wr(8'h04) |=> o_ctrl[19:13] == $past(i_req.wdata[6:0]))
		else $error("buck fields not written");
	a_sys_par_write: assert property (s_wr(8'h05) |=> o_ctrl[12:6] == $past(i_req.wdata[6:0]))
		else $error("system fields not written");
	a_slew_two_write: assert property (s_wr(8'h06) |=> o_ctrl[5:3] == $past(i_req.wdata[7:5]))
		else $error("buck two slew not written");
	a_slew_one_write: assert property (s_wr(8'h06) |=> o_ctrl[2:0] == $past(i_req.wdata[3:1]))
		else $error("buck one slew not written");
	a_buck_par_read: assert property (s_rd(8'h04) |=> o_rdata == {1'b0, $past(o_ctrl[19:13])})
		else $error("buck register read wrong");
	a_unmapped_read: assert property (i_req.rd && !i_req.wr && (i_req.addr < 8'h02 || i_req.addr > 8'h06)
		|=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_ack_follows_req: assert property ((i_req.wr || i_req.rd) |=> o_ack)
		else $error("access not acknowledged");
	a_ack_one_cycle: assert property (!(i_req.wr || i_req.rd) |=> !o_ack)
		else $error("acknowledge without access");
	a_addr_hit_map: assert property (o_addr_hit == (i_req.addr >= 8'h02 && i_req.addr <= 8'h06))
		else $error("address hit wrong");
	a_ldo_one_step: assert property (o_ldo_one_mv_step == {1'b0, o_ctrl.ldo_one_code})
		else $error("ldo one step count wrong");
endmodule : pmic_regs_checker
bind pmic_regulator_control_regs pmic_regs_checker u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_req(i_req),
	.o_ack(o_ack), .o_addr_hit(o_addr_hit), .o_rdata(o_rdata), .o_ctrl(o_ctrl),
	.o_ldo_one_mv_step(o_ldo_one_mv_step), .o_ldo_two_mv_step(o_ldo_two_mv_step));
`default_nettype wire

// >>> sim/pmic_host_model.sv
// host-side model issuing register accesses to the control bank
`timescale 1ns/1ps
`default_nettype none
module pmic_host_model (
	// clock
	input  wire logic                    i_mclk,
	// request and answer
	output var pmic_regs_pkg::reg_req_t  o_req,
	input  wire logic                    i_ack,
	input  wire logic [7:0]              i_rdata
);
	initial o_req = '0;
	// entered at a falling edge; request left up so calls run back to back
	task automatic xfer(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d,
		output logic k, output logic [7:0] q);
		o_req = '{wr: w, rd: r, addr: a, wdata: d};
		@(posedge i_mclk);
		@(negedge i_mclk);
		k = i_ack;
		q = i_rdata;
	endtask : xfer
	task automatic idle();
		o_req = '0;
	endtask : idle
endmodule : pmic_host_model
`default_nettype wire

// >>> sim/pmic_regulator_control_regs_tb.sv
// self-checking bench of the regulator control bank
`timescale 1ns/1ps
`default_nettype none
module pmic_regulator_control_regs_tb;
	typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rexp;} row_t;
	logic                     i_mclk = 1'b0;
	logic                     i_rst_n = 1'b0;
	pmic_regs_pkg::reg_req_t  req;
	logic                     ack;
	logic                     hit;
	logic [7:0]               rdata;
	pmic_regs_pkg::reg_ctrl_t ctrl;
	logic [6:0]               step_one;
	logic [6:0]               step_two;
	int                       error_cnt = 0;
	int                       n_tests = 0;
	logic [7:0]               rst_exp [2:6] = '{8'h0C, 8'h0C, 8'h0F, 8'h2F, 8'h22};
	row_t                     rows [11] = '{'{8'h02, 8'hFF, 8'h3F}, '{8'h03, 8'h36, 8'h36}, '{8'h04, 8'h80, 8'h00},
		'{8'h04, 8'hFF, 8'h7F}, '{8'h05, 8'h00, 8'h00}, '{8'h05, 8'hB0, 8'h30}, '{8'h05, 8'hD5, 8'h55},
		'{8'h06, 8'h11, 8'h00}, '{8'h06, 8'hFF, 8'hEE}, '{8'h01, 8'hFF, 8'h00}, '{8'h07, 8'hFF, 8'h00}};
	always #2.5 i_mclk = ~i_mclk;
	pmic_host_model host (.i_mclk(i_mclk), .o_req(req), .i_ack(ack), .i_rdata(rdata));
	pmic_regulator_control_regs uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_req(req), .o_ack(ack),
		.o_addr_hit(hit), .o_rdata(rdata), .o_ctrl(ctrl), .o_ldo_one_mv_step(step_one),
		.o_ldo_two_mv_step(step_two));
	task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic print_verdict();
		if (error_cnt == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict
	task automatic reset_check();
		logic       k;
		logic [7:0] q;
		check("ctrl defaults", ctrl, {6'h0C, 6'h0C, 7'h0F, 7'h2F, 3'h1, 3'h1});
		for (int i = 2; i < 7; i++) begin
			host.xfer(1'b0, 1'b1, 8'(i), 8'h00, k, q);
			check("reset readback", q, rst_exp[i]);
		end
		host.idle();
	endtask : reset_check
	initial begin
		#20000;
		error_cnt++;
		print_verdict();
	end
	initial begin
		logic       k;
		logic [7:0] q;
		repeat (3) @(posedge i_mclk);
		@(negedge i_mclk);
		i_rst_n = 1'b1;
		reset_check();
		foreach (rows[i]) begin
			host.xfer(1'b1, 1'b0, rows[i].addr, rows[i].wdata, k, q);
			check("write ack", k, 1'b1);
			check("addr hit", hit, rows[i].addr inside {[8'h02:8'h06]});
			host.xfer(1'b0, 1'b1, rows[i].addr, 8'h00, k, q);
			check("read ack", k, 1'b1);
			check("readback", q, rows[i].rexp);
		end
		host.idle();
		// unmapped writes above must have left every field alone
		check("ctrl after writes", ctrl, {6'h3F, 6'h36, 7'h7F, 7'h55, 3'h7, 3'h7});
		check("ldo one steps", step_one, 7'h3F);
		check("ldo two steps", step_two, 7'h36);
		for (int c = 0; c < 8; c++) begin
			host.xfer(1'b1, 1'b0, 8'h06, {3'(c), 1'b1, 3'(c), 1'b1}, k, q);
			check("slew codes", ctrl[5:0], {3'(c), 3'(c)});
		end
		host.idle();
		// second reset in mid-run brings every default back
		@(negedge i_mclk);
		i_rst_n = 1'b0;
		repeat (3) @(negedge i_mclk);
		i_rst_n = 1'b1;
		reset_check();
		// write and read in one cycle: read returns the old value
		host.xfer(1'b1, 1'b1, 8'h02, 8'h15, k, q);
		check("read during write", q, 8'h0C);
		check("ldo one code written", ctrl.ldo_one_code, 6'h15);
		host.idle();
		@(negedge i_mclk);
		check("ack drops when idle", ack, 1'b0);
		print_verdict();
	end
endmodule : pmic_regulator_control_regs_tb
`default_nettype wire
